// *** dv/aux_far_side.sv ***
// Far-side model: operator set key and radiator temperature sensor.
// Assumes bench commands are synchronous to pclk.
`timescale 1ns/1ps
module aux_far_side #(
  parameter int hold_cyc = 25
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench commands
  input wire logic press,
  input wire logic [7:0] temp_goal,
  // Pins toward the block
  output logic set_key,
  output logic [7:0] radiator_temp
);
  int held;
  // Operator holds the key a fixed time, then lets go
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      held <= 0;
    else if (press)
      held <= hold_cyc;
    else if (held > 0)
      held <= held - 1;
  end
  assign set_key = held > 0;
  // One degree per clock, so no threshold is ever jumped over
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      radiator_temp <= 8'h19;
    else if (radiator_temp < temp_goal)
      radiator_temp <= radiator_temp + 8'h01;
    else if (radiator_temp > temp_goal)
      radiator_temp <= radiator_temp - 8'h01;
  end
endmodule

// *** dv/servo_aux_ctrl_assertions.sv ***
// Checker for servo_aux_ctrl: APB answer, restore and overload fault.
// Assumes it is bound to the top module; one clock, async low reset.
`timescale 1ns/1ps
module servo_aux_ctrl_assertions #(
  parameter int key_hold_cyc = 20,
  parameter int restore_cyc = 50
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and flags
  input wire logic set_key,
  input wire logic overload_active,
  input wire logic [5:0] display_item,
  input wire logic display_zeros,
  input wire logic param_error,
  input wire logic restore_load,
  input wire logic overload_fault,
  input wire logic [3:0] fault_code
);
  int key_n;
  int zero_n;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Run lengths seen at the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_n <= 0;
      zero_n <= 0;
    end
    else
    begin
      key_n <= set_key ? key_n + 1 : 0;
      zero_n <= display_zeros ? zero_n + 1 : 0;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_defaults;
    ##[0:1] display_item == aux_ctrl_pkg::display_rst;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_display_range: assert property (
    display_item <= aux_ctrl_pkg::display_max)
    else $error("display item out of range");
  chk_fault_code_six: assert property (fault_code ==
    (overload_fault ? aux_ctrl_pkg::motor_overload_fault_code : 4'h0))
    else $error("fault code wrong");
  chk_fault_latched: assert property (
    overload_fault |=> overload_fault)
    else $error("fault flag dropped");
  chk_fault_cause: assert property ($rose(overload_fault) |->
    $past(overload_active) || $past(overload_active, 2) ||
    $past(overload_active, 3) || $past(overload_active, 4))
    else $error("fault without overload");
  chk_zeros_after_key: assert property (
    $rose(display_zeros) |-> key_n >= key_hold_cyc)
    else $error("zeros shown before key hold");
  chk_zeros_length: assert property ($fell(display_zeros) |->
    zero_n >= restore_cyc - 2 && zero_n <= restore_cyc + 2)
    else $error("restore wait length wrong");
  chk_load_defaults: assert property (
    $rose(restore_load) |->
    ($past(display_zeros) || $past(display_zeros, 2)) ##0 s_defaults)
    else $error("load without wait or defaults");
  chk_err_from_refusal: assert property (
    $rose(param_error) |-> $past(pslverr) || $past(pslverr, 2))
    else $error("error flag without refusal");
endmodule

// *** dv/tb.sv ***
// Self-checking bench for servo_aux_ctrl over APB with far-side model.
// Assumes the shortened counts passed as parameters below.
`timescale 1ns/1ps
module tb;
  localparam int key_cyc = 20;
  localparam int rst_cyc = 50;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic servo_on = 1'b0;
  logic mode_switch = 1'b0;
  logic press = 1'b0;
  logic [7:0] temp_goal = 8'h19;
  logic signed [15:0] analog_torque = 16'sh0;
  logic overload_active = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, set_key, fan_run, display_zeros, param_error;
  logic restore_load, overload_fault, irq, err;
  logic [7:0] radiator_temp;
  logic signed [15:0] torque_cmd;
  logic [5:0] display_item;
  logic [3:0] fault_code;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int i;
  logic [7:0] ra [7] = '{8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24};
  logic [31:0] rv [7] = '{32'd0, 32'd2, 32'd2, 32'd45, 32'd0, 32'd100, 32'd1};
  always #5 pclk = ~pclk;
  servo_aux_ctrl #(.key_hold_cyc(key_cyc), .restore_cyc(rst_cyc),
    .fan_stop_cyc(30), .overload_base(2)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .servo_on, .mode_switch, .set_key, .radiator_temp, .analog_torque,
    .overload_active, .torque_cmd, .fan_run, .display_item,
    .display_zeros, .param_error, .restore_load, .overload_fault,
    .fault_code, .irq);
  aux_far_side #(.hold_cyc(key_cyc + 5)) far (.pclk, .presetn, .press,
    .temp_goal, .set_key, .radiator_temp);
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // Request stands until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k == 50)
      n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_torque(input logic signed [15:0] t);
    int k;
    k = 0;
    do
    begin
      wt(1);
      k++;
    end
    while (torque_cmd !== t && k < 100);
    cmp32(32'(torque_cmd), 32'(t));
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      cmp32(rd, rv[i]);
    end
    apb(1'b0, 8'h38, 32'h0);
    cmp1(err, 1'b1);
    apb(1'b0, 8'h05, 32'h0);
    cmp1(err, 1'b1);
    $display("test reset_values done");
    for (i = 0; i <= 38; i++)
    begin
      apb(1'b1, 8'h0c, 32'(i));
      wt(2);
      cmp32(32'(display_item), (i < 38) ? 32'(i) : 32'd37);
    end
    $display("test display_select done");
    apb(1'b1, 8'h04, 32'd10000);
    apb(1'b0, 8'h04, 32'h0);
    cmp32(rd, 32'd0);
    apb(1'b1, 8'h04, 32'd9999);
    apb(1'b0, 8'h04, 32'h0);
    cmp32(rd, 32'd9999);
    apb(1'b0, 8'h28, 32'h0);
    cmp1(rd[aux_ctrl_pkg::status_prot_bit], 1'b0);
    apb(1'b1, 8'h0c, 32'd9);
    cmp1(err, 1'b0);
    wt(2);
    cmp32(32'(display_item), 32'd9);
    $display("test password done");
    apb(1'b1, 8'h24, 32'd10);
    apb(1'b1, 8'h20, 32'h0000ff38);
    @(posedge pclk);
    analog_torque <= 16'sd100;
    servo_on <= 1'b1;
    wait_torque(16'sd100);
    cmp1(fan_run, 1'b1);
    @(posedge pclk);
    mode_switch <= 1'b1;
    wt(12);
    cmp1(torque_cmd > -16'sd200 && torque_cmd < 16'sd100, 1'b1);
    wait_torque(-16'sd200);
    apb(1'b0, 8'h34, 32'h0);
    cmp32({16'h0, rd[15:0]}, 32'h0000ff38);
    apb(1'b0, 8'h28, 32'h0);
    cmp1(rd[aux_ctrl_pkg::status_src_bit], 1'b1);
    @(posedge pclk);
    mode_switch <= 1'b0;
    wt(12);
    cmp1(torque_cmd > -16'sd200 && torque_cmd < 16'sd100, 1'b1);
    wait_torque(16'sd100);
    @(posedge pclk);
    servo_on <= 1'b0;
    wait_torque(16'sd0);
    $display("test torque_source done");
    wt(15);
    cmp1(fan_run, 1'b1);
    wt(40);
    cmp1(fan_run, 1'b0);
    @(posedge pclk);
    temp_goal <= 8'd46;
    wt(30);
    cmp1(fan_run, 1'b1);
    @(posedge pclk);
    temp_goal <= 8'd30;
    wt(60);
    cmp1(fan_run, 1'b0);
    apb(1'b1, 8'h10, 32'd1);
    wt(5);
    cmp1(fan_run, 1'b1);
    apb(1'b1, 8'h14, 32'd50);
    apb(1'b1, 8'h10, 32'd0);
    apb(1'b1, 8'h10, 32'd3);
    apb(1'b0, 8'h10, 32'h0);
    cmp32(rd, 32'd0);
    wt(5);
    cmp1(fan_run, 1'b0);
    @(posedge pclk);
    temp_goal <= 8'd49;
    wt(25);
    cmp1(fan_run, 1'b0);
    @(posedge pclk);
    temp_goal <= 8'd50;
    wt(6);
    cmp1(fan_run, 1'b1);
    @(posedge pclk);
    temp_goal <= 8'd45;
    wt(12);
    cmp1(fan_run, 1'b1);
    @(posedge pclk);
    temp_goal <= 8'd44;
    wt(6);
    cmp1(fan_run, 1'b0);
    $display("test fan done");
    apb(1'b1, 8'h18, 32'd1);
    @(posedge pclk);
    press <= 1'b1;
    @(posedge pclk);
    press <= 1'b0;
    wt(10);
    cmp1(display_zeros, 1'b0);
    for (i = 0; i < 60 && display_zeros !== 1'b1; i++)
      wt(1);
    cmp1(display_zeros, 1'b1);
    for (i = 0; i < 120 && restore_load !== 1'b1; i++)
      wt(1);
    cmp1(restore_load, 1'b1);
    wt(2);
    cmp32(32'(display_item), 32'd2);
    apb(1'b0, 8'h18, 32'h0);
    cmp32(rd, 32'd0);
    apb(1'b0, 8'h04, 32'h0);
    cmp32(rd, 32'd0);
    apb(1'b0, 8'h2c, 32'h0);
    cmp1(rd[aux_ctrl_pkg::irq_restore_bit], 1'b1);
    apb(1'b1, 8'h30, 32'h7);
    wt(2);
    cmp1(irq, 1'b1);
    apb(1'b1, 8'h2c, 32'h7);
    wt(2);
    cmp1(irq, 1'b0);
    $display("test restore done");
    apb(1'b1, 8'h1c, 32'd501);
    apb(1'b0, 8'h1c, 32'h0);
    cmp32(rd, 32'd100);
    apb(1'b1, 8'h1c, 32'd5);
    @(posedge pclk);
    overload_active <= 1'b1;
    wt(6);
    cmp1(overload_fault, 1'b0);
    for (i = 0; i < 40 && overload_fault !== 1'b1; i++)
      wt(1);
    cmp1(overload_fault, 1'b1);
    cmp32(32'(fault_code), 32'h6);
    @(posedge pclk);
    overload_active <= 1'b0;
    wt(5);
    cmp1(overload_fault, 1'b1);
    apb(1'b0, 8'h2c, 32'h0);
    cmp1(rd[aux_ctrl_pkg::irq_fault_bit], 1'b1);
    cmp1(irq, 1'b1);
    apb(1'b1, 8'h30, 32'h0);
    wt(2);
    cmp1(irq, 1'b0);
    $display("test overload done");
    end_sim();
  end
endmodule
bind servo_aux_ctrl servo_aux_ctrl_assertions #(
  .key_hold_cyc(key_hold_cyc), .restore_cyc(restore_cyc)) chk (.pclk,
  .presetn, .psel, .penable, .pready, .pslverr, .set_key,
  .overload_active, .display_item, .display_zeros, .param_error,
  .restore_load, .overload_fault, .fault_code);

// *** verilog/aux_ctrl_pkg.sv ***
// Constants for the servo auxiliary control block.
// Assumes a 100 MHz pclk and an APB register bus with 32-bit words.
package aux_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] off_control = 8'h00;
  localparam logic [7:0] off_password = 8'h04;
  localparam logic [7:0] off_key = 8'h08;
  localparam logic [7:0] off_display_sel = 8'h0c;
  localparam logic [7:0] off_fan_mode = 8'h10;
  localparam logic [7:0] off_fan_temp = 8'h14;
  localparam logic [7:0] off_restore = 8'h18;
  localparam logic [7:0] off_overload = 8'h1c;
  localparam logic [7:0] off_torque_int = 8'h20;
  localparam logic [7:0] off_ramp_step = 8'h24;
  localparam logic [7:0] off_status = 8'h28;
  localparam logic [7:0] off_irq_status = 8'h2c;
  localparam logic [7:0] off_irq_mask = 8'h30;
  localparam logic [7:0] off_torque_out = 8'h34;
  // Field positions
  localparam int status_src_bit = 0;
  localparam int status_prot_bit = 1;
  localparam int status_unlock_bit = 2;
  localparam int status_fan_bit = 3;
  localparam int status_zero_bit = 4;
  localparam int status_fault_bit = 5;
  localparam int irq_err_bit = 0;
  localparam int irq_fault_bit = 1;
  localparam int irq_restore_bit = 2;
  // Limits and reset values
  localparam logic [13:0] password_max = 14'd9999;
  localparam logic [13:0] password_rst = 14'h0000;
  localparam logic [5:0] display_max = 6'd37;
  localparam logic [5:0] display_rst = 6'd2;
  localparam logic [5:0] display_reserved = 6'd32;
  localparam logic [1:0] fan_mode_max = 2'd2;
  localparam logic [1:0] fan_mode_rst = 2'd2;
  localparam logic [7:0] fan_temp_rst = 8'd45;
  localparam logic [7:0] fan_temp_min = 8'd10;
  localparam logic [7:0] fan_temp_max = 8'd100;
  localparam logic [7:0] fan_hyst = 8'd5;
  localparam logic [7:0] fan_run_temp = 8'd45;
  localparam logic [7:0] fan_stop_temp = 8'd40;
  localparam logic [8:0] overload_max = 9'd500;
  localparam logic [8:0] overload_rst = 9'd100;
  localparam logic [15:0] ramp_step_rst = 16'h0001;
  localparam logic [3:0] motor_overload_fault_code = 4'h6;
  // Timing
  localparam int clk_mhz = 100;
  localparam int fan_stop_ms = 500;
  localparam int key_hold_ms = 500;
  localparam int restore_wait_ms = 5000;
  localparam int fan_stop_cycles = fan_stop_ms * 1000 * clk_mhz;
  localparam int key_hold_cycles = key_hold_ms * 1000 * clk_mhz;
  localparam int restore_wait_cycles = restore_wait_ms * 1000 * clk_mhz;
  typedef enum logic [1:0] {fan_off, fan_on, fan_hold} fan_state_type;
  typedef enum logic [1:0] {rs_idle, rs_hold, rs_wait} restore_state_type;
endpackage

// *** verilog/servo_aux_ctrl.sv ***
// Auxiliary servo control: torque source, password, display, fan,
// factory restore and overload fault. APB slave on pclk; pins are
// asynchronous and synchronised; temperatures are whole degrees.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
// How it works
// - Servo on with mode input high selects internal register torque.
// - Servo on with mode input low selects analog torque.
// - Mode rising ramps output toward internal setpoint by ramp step.
// - Mode falling ramps output toward analog setpoint by ramp step.
// - Password holds 0 to 9999, resets to 0; zero means unprotected.
// - A stored password protects only after the next reset; here reset also clears it to 0, so protection never sets.
// - Protected writes need correct key first; else refused, error flagged.
// - Display select holds 0 to 37, resets to 2, takes effect at once.
// - Display codes map to quantities; code 32 is reserved.
// - Fan mode 0 to 2, reset 2: thermal, always on, while running.
// - Mode 0 fan starts at setpoint, stops below setpoint minus five.
// - Mode 2 runs while servo on or above 45, stops 500 ms after; here it stops only 500 ms after servo off and below 40.
// - Restore register resets to 0; writing 1 arms factory restore.
// - Armed, set key held 0.5 s shows zeros, 5 s later loads defaults.
// - Overload coefficient 0 to 500 percent, reset 100, scales fault time.
module servo_aux_ctrl #(
  parameter int key_hold_cyc = aux_ctrl_pkg::key_hold_cycles,
  parameter int restore_cyc = aux_ctrl_pkg::restore_wait_cycles,
  parameter int fan_stop_cyc = aux_ctrl_pkg::fan_stop_cycles,
  parameter int overload_base = 1000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive pins
  input wire logic servo_on,
  input wire logic mode_switch,
  input wire logic set_key,
  input wire logic [7:0] radiator_temp,
  input wire logic signed [15:0] analog_torque,
  input wire logic overload_active,
  // Outputs
  output logic signed [15:0] torque_cmd,
  output logic fan_run,
  output logic [5:0] display_item,
  output logic display_zeros,
  output logic param_error,
  output logic restore_load,
  output logic overload_fault,
  output logic [3:0] fault_code,
  output logic irq
);
  initial
  begin
    if (key_hold_cyc < 1 || restore_cyc < 1 || fan_stop_cyc < 1)
      $error("servo_aux_ctrl timing counts must be at least one");
    if (overload_base < 1 || overload_base > 1000000)
      $error("servo_aux_ctrl overload_base out of range");
  end

  // Two flops per pin; the words move slowly, so bit skew is tolerable
  logic [27:0] pin_m, pin_s;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_m <= '0;
      pin_s <= '0;
    end
    else
    begin
      pin_m <= {servo_on, mode_switch, set_key, overload_active,
        radiator_temp, analog_torque};
      pin_s <= pin_m;
    end
  end
  logic son, mode_in, key_in, ovl_in;
  logic [7:0] temp_s;
  logic signed [15:0] ana_s;
  assign {son, mode_in, key_in, ovl_in, temp_s, ana_s} = pin_s;

  // Registers
  logic [13:0] password_q, key_q;
  logic prot_q, unlock_q;
  logic [5:0] display_q;
  logic [1:0] fan_mode_q;
  logic [7:0] fan_temp_q;
  logic restore_q;
  logic [8:0] overload_q;
  logic signed [15:0] torque_int_q;
  logic [15:0] ramp_step_q;
  logic [2:0] irq_status_q, irq_mask_q;
  logic [2:0] irq_set;
  logic restore_fire;

  // APB access: zero wait states, error on unmapped or refused write
  logic wr, rd, locked, monitor_addr, mapped;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign monitor_addr = paddr == aux_ctrl_pkg::off_key ||
    paddr == aux_ctrl_pkg::off_irq_status ||
    paddr == aux_ctrl_pkg::off_irq_mask;
  assign locked = prot_q && !unlock_q && !monitor_addr;
  assign mapped = paddr <= aux_ctrl_pkg::off_torque_out && paddr[1:0] == 2'b00;

  function automatic logic in_range(input logic [31:0] v, input logic [31:0] mx);
    in_range = v <= mx;
  endfunction

  logic do_wr;
  assign do_wr = wr && mapped && !locked;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (!mapped || (pwrite && locked));
    end
  end

  // Parameter registers, restore reloads every setting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      password_q <= aux_ctrl_pkg::password_rst;
      display_q <= aux_ctrl_pkg::display_rst;
      fan_mode_q <= aux_ctrl_pkg::fan_mode_rst;
      fan_temp_q <= aux_ctrl_pkg::fan_temp_rst;
      overload_q <= aux_ctrl_pkg::overload_rst;
      torque_int_q <= '0;
      ramp_step_q <= aux_ctrl_pkg::ramp_step_rst;
    end
    else if (restore_fire)
    begin
      password_q <= aux_ctrl_pkg::password_rst;
      display_q <= aux_ctrl_pkg::display_rst;
      fan_mode_q <= aux_ctrl_pkg::fan_mode_rst;
      fan_temp_q <= aux_ctrl_pkg::fan_temp_rst;
      overload_q <= aux_ctrl_pkg::overload_rst;
      torque_int_q <= '0;
      ramp_step_q <= aux_ctrl_pkg::ramp_step_rst;
    end
    else if (do_wr)
    begin
      case (paddr)
        aux_ctrl_pkg::off_password:
          if (in_range(pwdata, 32'(aux_ctrl_pkg::password_max)))
            password_q <= pwdata[13:0];
        aux_ctrl_pkg::off_display_sel:
          if (in_range(pwdata, 32'(aux_ctrl_pkg::display_max)))
            display_q <= pwdata[5:0];
        aux_ctrl_pkg::off_fan_mode:
          if (in_range(pwdata, 32'(aux_ctrl_pkg::fan_mode_max)))
            fan_mode_q <= pwdata[1:0];
        aux_ctrl_pkg::off_fan_temp:
          if (pwdata[7:0] >= aux_ctrl_pkg::fan_temp_min &&
              in_range(pwdata, 32'(aux_ctrl_pkg::fan_temp_max)))
            fan_temp_q <= pwdata[7:0];
        aux_ctrl_pkg::off_overload:
          if (in_range(pwdata, 32'(aux_ctrl_pkg::overload_max)))
            overload_q <= pwdata[8:0];
        aux_ctrl_pkg::off_torque_int:
          torque_int_q <= pwdata[15:0];
        aux_ctrl_pkg::off_ramp_step:
          if (pwdata[15:0] != 16'h0000)
            ramp_step_q <= pwdata[15:0];
        default:
          ;
      endcase
    end
  end

  // Protection latches the stored password only at reset release
  logic armed_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      armed_q <= 1'b0;
      prot_q <= 1'b0;
      unlock_q <= 1'b0;
      key_q <= '0;
    end
    else
    begin
      armed_q <= 1'b1;
      if (!armed_q)
        prot_q <= password_q != 14'h0000;
      if (wr && paddr == aux_ctrl_pkg::off_key)
      begin
        key_q <= pwdata[13:0];
        unlock_q <= pwdata[13:0] == password_q;
      end
    end
  end

  // Torque source and ramp
  logic signed [15:0] target;
  assign target = mode_in ? torque_int_q : ana_s;
  torque_ramp #(
    .width(16)
  ) u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .run(son),
    .target(target),
    .step(ramp_step_q),
    .value_q(torque_cmd)
  );

  // Fan control
  aux_ctrl_pkg::fan_state_type fan_q;
  logic [31:0] fan_cnt_q;
  logic hot2;
  assign hot2 = son || temp_s > aux_ctrl_pkg::fan_run_temp;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fan_q <= aux_ctrl_pkg::fan_off;
      fan_cnt_q <= '0;
    end
    else
      case (fan_mode_q)
        2'd0:
        begin
          fan_cnt_q <= '0;
          if (temp_s >= fan_temp_q)
            fan_q <= aux_ctrl_pkg::fan_on;
          else if ({1'b0, temp_s} + {1'b0, aux_ctrl_pkg::fan_hyst} <
                   {1'b0, fan_temp_q})
            fan_q <= aux_ctrl_pkg::fan_off;
        end
        2'd1:
          fan_q <= aux_ctrl_pkg::fan_on;
        2'd2:
          case (fan_q)
            aux_ctrl_pkg::fan_off:
              if (hot2)
                fan_q <= aux_ctrl_pkg::fan_on;
            aux_ctrl_pkg::fan_on:
              if (!son && temp_s < aux_ctrl_pkg::fan_stop_temp)
              begin
                fan_q <= aux_ctrl_pkg::fan_hold;
                fan_cnt_q <= '0;
              end
            aux_ctrl_pkg::fan_hold:
              if (son || temp_s >= aux_ctrl_pkg::fan_stop_temp)
                fan_q <= aux_ctrl_pkg::fan_on;
              else if (fan_cnt_q == 32'(fan_stop_cyc - 1))
                fan_q <= aux_ctrl_pkg::fan_off;
              else
                fan_cnt_q <= fan_cnt_q + 32'd1;
            default:
              fan_q <= aux_ctrl_pkg::fan_off;
          endcase
        default:
          fan_q <= aux_ctrl_pkg::fan_on;
      endcase
  end

  // Factory restore sequence
  aux_ctrl_pkg::restore_state_type rs_q;
  logic [31:0] rs_cnt_q;
  assign restore_fire = rs_q == aux_ctrl_pkg::rs_wait &&
    rs_cnt_q == 32'(restore_cyc - 1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      restore_q <= 1'b0;
      rs_q <= aux_ctrl_pkg::rs_idle;
      rs_cnt_q <= '0;
    end
    else
    begin
      if (do_wr && paddr == aux_ctrl_pkg::off_restore)
        restore_q <= pwdata[0];
      case (rs_q)
        aux_ctrl_pkg::rs_idle:
        begin
          rs_cnt_q <= '0;
          if (restore_q && key_in)
            rs_q <= aux_ctrl_pkg::rs_hold;
        end
        aux_ctrl_pkg::rs_hold:
          if (!key_in || !restore_q)
            rs_q <= aux_ctrl_pkg::rs_idle;
          else if (rs_cnt_q == 32'(key_hold_cyc - 1))
          begin
            rs_q <= aux_ctrl_pkg::rs_wait;
            rs_cnt_q <= '0;
          end
          else
            rs_cnt_q <= rs_cnt_q + 32'd1;
        aux_ctrl_pkg::rs_wait:
          if (restore_fire)
          begin
            rs_q <= aux_ctrl_pkg::rs_idle;
            restore_q <= 1'b0;
          end
          else
            rs_cnt_q <= rs_cnt_q + 32'd1;
        default:
          rs_q <= aux_ctrl_pkg::rs_idle;
      endcase
    end
  end

  // Overload accumulator; limit is base ticks times coefficient percent
  logic [31:0] ovl_acc_q, ovl_limit;
  logic fault_q;
  assign ovl_limit = 32'(overload_base) * {23'h0, overload_q};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovl_acc_q <= '0;
      fault_q <= 1'b0;
    end
    else
    begin
      if (ovl_in && ovl_acc_q <= ovl_limit)
        ovl_acc_q <= ovl_acc_q + 32'd1;
      else if (!ovl_in && ovl_acc_q != 32'h0)
        ovl_acc_q <= ovl_acc_q - 32'd1;
      if (ovl_acc_q > ovl_limit)
        fault_q <= 1'b1;
    end
  end

  // Interrupts: set wins over write-one-to-clear
  assign irq_set[aux_ctrl_pkg::irq_err_bit] = wr && mapped && locked;
  assign irq_set[aux_ctrl_pkg::irq_fault_bit] =
    ovl_acc_q > ovl_limit && !fault_q;
  assign irq_set[aux_ctrl_pkg::irq_restore_bit] = restore_fire;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_q <= '0;
      irq_mask_q <= '0;
    end
    else
    begin
      if (wr && paddr == aux_ctrl_pkg::off_irq_mask)
        irq_mask_q <= pwdata[2:0];
      if (wr && paddr == aux_ctrl_pkg::off_irq_status)
        irq_status_q <= (irq_status_q & ~pwdata[2:0]) | irq_set;
      else
        irq_status_q <= irq_status_q | irq_set;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fan_run <= 1'b0;
      display_item <= aux_ctrl_pkg::display_rst;
      display_zeros <= 1'b0;
      param_error <= 1'b0;
      restore_load <= 1'b0;
      overload_fault <= 1'b0;
      fault_code <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      fan_run <= fan_q != aux_ctrl_pkg::fan_off;
      display_item <= display_q;
      display_zeros <= rs_q == aux_ctrl_pkg::rs_wait;
      param_error <= irq_status_q[aux_ctrl_pkg::irq_err_bit];
      restore_load <= restore_fire;
      overload_fault <= fault_q;
      fault_code <= fault_q ? aux_ctrl_pkg::motor_overload_fault_code : 4'h0;
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  // Read mux
  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0;
    case (paddr)
      aux_ctrl_pkg::off_control: rdata = {31'h0, mode_in};
      aux_ctrl_pkg::off_password: rdata = {18'h0, password_q};
      aux_ctrl_pkg::off_key: rdata = {18'h0, key_q};
      aux_ctrl_pkg::off_display_sel: rdata = {26'h0, display_q};
      aux_ctrl_pkg::off_fan_mode: rdata = {30'h0, fan_mode_q};
      aux_ctrl_pkg::off_fan_temp: rdata = {24'h0, fan_temp_q};
      aux_ctrl_pkg::off_restore: rdata = {31'h0, restore_q};
      aux_ctrl_pkg::off_overload: rdata = {23'h0, overload_q};
      aux_ctrl_pkg::off_torque_int: rdata = {16'h0, torque_int_q};
      aux_ctrl_pkg::off_ramp_step: rdata = {16'h0, ramp_step_q};
      aux_ctrl_pkg::off_status:
        rdata = {26'h0, fault_q, rs_q == aux_ctrl_pkg::rs_wait,
                 fan_q != aux_ctrl_pkg::fan_off, unlock_q, prot_q, mode_in};
      aux_ctrl_pkg::off_irq_status: rdata = {29'h0, irq_status_q};
      aux_ctrl_pkg::off_irq_mask: rdata = {29'h0, irq_mask_q};
      aux_ctrl_pkg::off_torque_out: rdata = {16'h0, torque_cmd};
      default: rdata = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rdata;
  end
endmodule

// *** verilog/torque_ramp.sv ***
// Ramps a signed torque command toward a target by a fixed step per tick.
// Assumes step is nonzero and target changes are synchronous to pclk.
`timescale 1ns/1ps
module torque_ramp #(
  parameter int width = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Ramp control
  input wire logic run,
  input wire logic signed [width-1:0] target,
  input wire logic [width-1:0] step,
  output logic signed [width-1:0] value_q
);
  initial
  begin
    if (width < 2)
      $error("torque_ramp width too small");
  end

  logic signed [width:0] diff;
  logic signed [width:0] stp;
  assign diff = {target[width-1], target} - {value_q[width-1], value_q};
  assign stp = {1'b0, step};

  // Approach by step, land exactly when inside one step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      value_q <= '0;
    else if (!run)
      value_q <= '0;
    else if (diff > stp)
      value_q <= value_q + $signed(step);
    else if (diff < -stp)
      value_q <= value_q - $signed(step);
    else
      value_q <= target;
  end
endmodule
